// >>> rtl/mbu_pkg.sv
// constants, field layouts and carrier types for the macroblock inline unpacker
// assumes inline dwords are numbered from dword 0 of the pack command
package mbu_pkg;

  // ****************************************
  // inline dword numbers
  // ****************************************
  localparam int unsigned DW_COUNT = 24;         // dwords kept per command
  localparam logic [4:0] DW_HDR   = 5'h03;       // type, intra flag, modes
  localparam logic [4:0] DW_QP    = 5'h06;       // skip conv and quantizer
  localparam logic [4:0] DW_SUB   = 5'h07;       // sub shapes, inter only
  localparam logic [4:0] DW_REF0  = 5'h08;       // list 0 reference bytes
  localparam logic [4:0] DW_REF1  = 5'h09;       // list 1 reference bytes
  localparam logic [4:0] DW_BUDG  = 5'h0a;       // budgets and lambda
  localparam logic [4:0] DW_MVF   = 5'h0c;       // first forward vector
  localparam logic [4:0] DW_MVB   = 5'h10;       // first backward vector
  localparam logic [4:0] DW_MODE  = 5'h14;       // luma modes 0 and 1
  localparam logic [4:0] DW_DIST  = 5'h16;       // best and skip cost
  localparam logic [4:0] DW_LAST  = 5'h17;       // inter and intra cost

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned HDR_INTRA_BIT = 13;
  localparam int unsigned SKIP_CONV_BIT = 25;
  localparam logic [3:0]  TRELLIS_OFF   = 4'hf;  // lambda top nibble

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [4:0]  REG_CTRL   = 5'h00;
  localparam logic [4:0]  REG_STAT   = 5'h04;
  localparam logic [4:0]  REG_QP     = 5'h08;
  localparam logic [4:0]  REG_LAMBDA = 5'h0c;
  localparam logic [6:0]  CTRL_RESET = 7'h00;
  localparam int unsigned CTRL_TQ    = 0;        // trellis_quant_on
  localparam int unsigned CTRL_TQR   = 1;        // trellis_round_setting 3:1
  localparam int unsigned CTRL_REPL  = 4;        // replicated_layout_flag
  localparam int unsigned CTRL_T8    = 5;        // large_transform_flag
  localparam int unsigned CTRL_SKIP  = 6;        // global skip conversion off

  // inter partition shape, low bits of the header dword
  typedef enum logic [1:0] {
    PART_16X16 = 2'b00,
    PART_16X8  = 2'b01,
    PART_8X16  = 2'b10,
    PART_8X8   = 2'b11
  } mbu_part_type;

  // decoded fields of one macroblock
  typedef struct packed {
    logic              skip_conversion_off;
    logic              intra_coded_flag;
    logic [7:0]        luma_quantizer;
    logic [7:0]        size_ceiling_words;
    logic [7:0]        size_goal_words;
    logic              trellis_active;
    logic [16:0]       lambda_x2;
    logic              round_from_slice;
    logic              round_from_trellis;
    logic              round_reserved;
    logic [3:0]        round_sixteenths;
    logic [3:0][31:0]  mv_fwd;          // {y, x} per block
    logic [3:0][31:0]  mv_bwd;
    logic [63:0]       luma_pred_modes;
    logic [1:0]        intra16_mode;
    logic [31:0]       ref_l0;
    logic [31:0]       ref_l1;
    logic [7:0]        layout_aux;      // sub shapes or avail flags
    logic [15:0]       best_cost;
    logic [15:0]       skip_cost;
    logic [15:0]       inter_cost;
    logic [15:0]       intra_cost;
  } mbu_fields_type;

endpackage

// >>> rtl/mbu_layout_expand.sv
// expands luma modes and reference bytes into per-block vectors
// assumes inputs are the latched dwords of one complete command
`timescale 1ns/1ns
`default_nettype none

module mbu_layout_expand (
  input  wire logic        is_intra,     // intra macroblock
  input  wire logic [4:0]  mb_type,      // 0 means NxN intra
  input  wire logic        large_xform,  // 8x8 transform
  input  wire logic        replicated,   // extended layout
  input  wire logic [1:0]  inter_part,   // partition shape
  input  wire logic [31:0] mode_lo,      // luma modes 1:0
  input  wire logic [31:0] mode_hi,      // luma modes 3:2
  input  wire logic [31:0] ref0_raw,     // list 0 bytes
  input  wire logic [31:0] ref1_raw,     // list 1 bytes
  output logic      [63:0] luma_vec,
  output logic      [1:0]  intra16_mode,
  output logic      [31:0] ref0_vec,
  output logic      [31:0] ref1_vec
);

  // ****************************************
  // reference byte expansion
  // ****************************************
  // same decode for both lists
  function automatic logic [31:0] ref_expand(
    input logic [31:0] raw,
    input logic [1:0]  part,
    input logic        repl
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (mbu_pkg::mbu_part_type'(part))
      mbu_pkg::PART_16X16: r = repl ? {4{raw[7:0]}} : {24'h00_0000, raw[7:0]};
      mbu_pkg::PART_16X8:  r = {16'h0000, raw[15:0]};
      mbu_pkg::PART_8X16:  r = repl ? {2{raw[15:0]}} : {16'h0000, raw[15:0]};
      mbu_pkg::PART_8X8:   r = raw;                  // every byte its own block
    endcase
    return r;
  endfunction

  logic [63:0] raw_modes;  // block 0 in lowest nibble
  logic [63:0] modes_8x8;  // one lane per 8x8 block
  logic        nxn;        // 4x4 or 8x8 prediction

  assign raw_modes = {mode_hi, mode_lo};
  assign nxn       = (mb_type == 5'h00);

  // 8x8 lanes carry one nibble of mode field 0 each
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign modes_8x8[16*g +: 16] = {12'h000, mode_lo[4*g +: 4]};
    end
  endgenerate

  // ****************************************
  // layout select, intra or inter
  // ****************************************
  always_comb begin
    luma_vec     = 64'h0;
    intra16_mode = 2'b00;
    ref0_vec     = 32'h0;
    ref1_vec     = 32'h0;
    if (is_intra) begin
      intra16_mode = mode_lo[1:0];
      if (replicated || (nxn && !large_xform)) begin
        luma_vec = raw_modes;
      end else if (nxn) begin
        luma_vec = modes_8x8;
      end else begin
        luma_vec = {16{mode_lo[3:0]}};
      end
    end else begin
      ref0_vec = ref_expand(ref0_raw, inter_part, replicated);
      ref1_vec = ref_expand(ref1_raw, inter_part, replicated);
    end
  end

endmodule

`default_nettype wire

// >>> rtl/mbu_unpacker.sv
// macroblock inline data unpacker with avalon register slave
// assumes the command parser and packer run on clk_sys
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - skip conversion bit 1 suppresses conversion
// - chroma quantizer bytes ignored, derived internally
// - low byte is luma quantizer, 0..51
// - dwords 7..9 decoded by intra/inter
// - over size ceiling enters emergency mode
// - over size goal limits nonzero coefficients
// - trellis on: lambda is field doubled
// - top nibble ones disables trellis
// - no trellis: low nibble picks rounding
// - trellis active rounds from picture setting
// - dwords 12..15 forward vectors, y high
// - dwords 16..19 backward vectors, same split
// - dwords 20,21 hold four mode fields
// - 16x16 intra uses two mode bits
// - dword 22 best and skip cost
// - dword 23 inter and intra cost
// - 4x4 vector block 0 lowest nibble
// - 16x16 replicates mode nibble sixteen times unless replicated layout
// - reference bytes expand per partition shape
// - fields held until reset or next command
module mbu_unpacker (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  // inline dword stream from command parser
  input  wire logic                    dw_valid,
  input  wire logic [4:0]              dw_index,
  input  wire logic [31:0]             dw_data,
  input  wire logic                    dw_last,
  // packer progress, accumulated words
  input  wire logic [15:0]             packed_words,
  // avalon-mm slave
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // decoded fields to packer
  output mbu_pkg::mbu_fields_type      mb_fields,
  output logic                         mb_fields_valid,
  output logic                         overflow_emergency_mode,
  output logic                         coeff_limit
);

  // ****************************************
  // storage
  // ****************************************
  logic [31:0] shadow_r [mbu_pkg::DW_COUNT];  // raw dwords of open command
  logic [6:0]  ctrl_r;                        // software control bits
  logic        overflow_emergency_mode_seen_r;                  // sticky emergency flag
  logic        rsv_seen_r;                    // sticky reserved rounding
  logic [7:0]  commit_cnt_r;                  // commands decoded, wraps
  logic        commit_r;                      // last dword taken
  logic        wait_r;                        // bus wait state
  logic [31:0] rdata_r;                       // bus read data
  mbu_pkg::mbu_fields_type fields_r;          // presented fields
  logic        fvalid_r;                      // one cycle after commit
  logic        overflow_emergency_mode_r;                       // live emergency level
  logic        limit_r;                       // live coefficient limit

  // control bit views
  logic        trellis_quant_on;
  logic [2:0]  trellis_round_setting;
  logic        replicated_layout_flag;
  logic        large_transform_flag;
  logic        global_skip_off;

  assign trellis_quant_on       = ctrl_r[mbu_pkg::CTRL_TQ];
  assign trellis_round_setting  = ctrl_r[mbu_pkg::CTRL_TQR +: 3];
  assign replicated_layout_flag = ctrl_r[mbu_pkg::CTRL_REPL];
  assign large_transform_flag   = ctrl_r[mbu_pkg::CTRL_T8];
  assign global_skip_off        = ctrl_r[mbu_pkg::CTRL_SKIP];

  // ****************************************
  // dword capture
  // ****************************************
  // no reset on the array: contents only matter once committed
  always_ff @(posedge clk_sys) begin
    if (dw_valid && (dw_index <= mbu_pkg::DW_LAST)) begin
      shadow_r[dw_index] <= dw_data;
    end
  end

  // commit strobe, delayed so the last dword is in the array
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      commit_r <= 1'b0;
    end else begin
      commit_r <= dw_valid && dw_last;
    end
  end

  // ****************************************
  // combinational decode of latched dwords
  // ****************************************
  logic [31:0] hdr;      // header dword
  logic [31:0] qpw;      // quantizer dword
  logic [31:0] budg;     // budget dword
  logic [15:0] lam;      // weight or rounding field
  logic        tq_act;   // trellis really used
  logic [63:0] luma_vec;
  logic [1:0]  i16_mode;
  logic [31:0] ref0_vec;
  logic [31:0] ref1_vec;
  mbu_pkg::mbu_fields_type dec;

  assign hdr  = shadow_r[mbu_pkg::DW_HDR];
  assign qpw  = shadow_r[mbu_pkg::DW_QP];
  assign budg = shadow_r[mbu_pkg::DW_BUDG];
  assign lam  = budg[15:0];  // trellis_weight_or_round
  // all-ones top nibble turns trellis off for this block
  assign tq_act = trellis_quant_on && (lam[15:12] != mbu_pkg::TRELLIS_OFF);

  // block vector expansion
  mbu_layout_expand u_expand (
    .is_intra     (hdr[mbu_pkg::HDR_INTRA_BIT]),
    .mb_type      (hdr[12:8]),
    .large_xform  (large_transform_flag),
    .replicated   (replicated_layout_flag),
    .inter_part   (hdr[1:0]),
    .mode_lo      (shadow_r[mbu_pkg::DW_MODE]),
    .mode_hi      (shadow_r[mbu_pkg::DW_MODE + 5'h01]),
    .ref0_raw     (shadow_r[mbu_pkg::DW_REF0]),
    .ref1_raw     (shadow_r[mbu_pkg::DW_REF1]),
    .luma_vec     (luma_vec),
    .intra16_mode (i16_mode),
    .ref0_vec     (ref0_vec),
    .ref1_vec     (ref1_vec)
  );

  // field assembly
  always_comb begin
    dec = '0;
    // per-block flag or'd with the global one
    dec.skip_conversion_off = qpw[mbu_pkg::SKIP_CONV_BIT] | global_skip_off;
    dec.intra_coded_flag    = hdr[mbu_pkg::HDR_INTRA_BIT];
    // chroma bytes 23:16 and 15:8 never looked at
    dec.luma_quantizer      = qpw[7:0];
    dec.size_ceiling_words  = budg[31:24];
    dec.size_goal_words     = budg[23:16];
    dec.trellis_active      = tq_act;
    // doubled weight only meaningful when trellis runs
    dec.lambda_x2           = tq_act ? {lam, 1'b0} : 17'h0_0000;
    if (tq_act) begin
      dec.round_from_trellis = 1'b1;
      dec.round_sixteenths   = {1'b0, trellis_round_setting};
    end else if (lam[3]) begin
      // 1000b..1111b give one to eight sixteenths
      dec.round_sixteenths   = 4'({1'b0, lam[2:0]} + 4'h1);
    end else begin
      // 0000b and reserved codes fall back to slice rounding
      dec.round_from_slice   = 1'b1;
      dec.round_reserved     = (lam[2:0] != 3'h0);
    end
    for (int b = 0; b < 4; b++) begin
      dec.mv_fwd[b] = shadow_r[mbu_pkg::DW_MVF + 5'(b)];
      dec.mv_bwd[b] = shadow_r[mbu_pkg::DW_MVB + 5'(b)];
    end
    dec.luma_pred_modes = luma_vec;
    dec.intra16_mode    = i16_mode;
    dec.ref_l0          = ref0_vec;
    dec.ref_l1          = ref1_vec;
    // dword 7 low byte sub shapes for inter, dword 9 low byte avail flags for intra
    dec.layout_aux = hdr[mbu_pkg::HDR_INTRA_BIT] ? shadow_r[mbu_pkg::DW_REF1][7:0]
                                                 : shadow_r[mbu_pkg::DW_SUB][7:0];
    dec.best_cost  = shadow_r[mbu_pkg::DW_DIST][31:16];
    dec.skip_cost  = shadow_r[mbu_pkg::DW_DIST][15:0];
    dec.inter_cost = shadow_r[mbu_pkg::DW_LAST][31:16];
    dec.intra_cost = shadow_r[mbu_pkg::DW_LAST][15:0];
  end

  // ****************************************
  // presented fields
  // ****************************************
  // fields only change on a commit, so no mixing across blocks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fields_r <= '0;
      fvalid_r <= 1'b0;
    end else begin
      fvalid_r <= commit_r;
      if (commit_r) begin
        fields_r <= dec;
      end
    end
  end

  // ****************************************
  // budget comparison
  // ****************************************
  // compares against the fields currently presented
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overflow_emergency_mode_r <= 1'b0;
      limit_r <= 1'b0;
    end else begin
      overflow_emergency_mode_r <= packed_words > {8'h00, fields_r.size_ceiling_words};
      limit_r <= packed_words > {8'h00, fields_r.size_goal_words};
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  logic req;      // any request
  logic done;     // request completes this edge
  logic wr_ok;    // write to low byte takes effect
  assign req   = avs_read || avs_write;
  assign done  = req && !wait_r;
  assign wr_ok = done && avs_write && avs_byteenable[0];

  // one wait state per access: low for one cycle after a request
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(req && wait_r);
    end
  end

  // control register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r <= mbu_pkg::CTRL_RESET;
    end else if (wr_ok && (avs_address == mbu_pkg::REG_CTRL)) begin
      ctrl_r <= avs_writedata[6:0];
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overflow_emergency_mode_seen_r <= 1'b0;
      rsv_seen_r   <= 1'b0;
    end else begin
      if (overflow_emergency_mode_r) begin
        overflow_emergency_mode_seen_r <= 1'b1;
      end else if (wr_ok && (avs_address == mbu_pkg::REG_STAT) && avs_writedata[0]) begin
        overflow_emergency_mode_seen_r <= 1'b0;
      end
      if (commit_r && dec.round_reserved) begin
        rsv_seen_r <= 1'b1;
      end else if (wr_ok && (avs_address == mbu_pkg::REG_STAT) && avs_writedata[2]) begin
        rsv_seen_r <= 1'b0;
      end
    end
  end

  // command counter, shows decode progress
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      commit_cnt_r <= 8'h00;
    end else if (commit_r) begin
      commit_cnt_r <= commit_cnt_r + 8'h01;
    end
  end

  // read data, loaded on the edge that drops waitrequest
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && wait_r) begin
      unique case (avs_address)
        mbu_pkg::REG_CTRL:   rdata_r <= {25'h000_0000, ctrl_r};
        mbu_pkg::REG_STAT:   rdata_r <= {16'h0000, commit_cnt_r, 5'h00,
                                         rsv_seen_r, limit_r, overflow_emergency_mode_seen_r};
        mbu_pkg::REG_QP:     rdata_r <= {fields_r.size_ceiling_words, fields_r.size_goal_words,
                                         7'h00, fields_r.trellis_active,
                                         fields_r.luma_quantizer};
        mbu_pkg::REG_LAMBDA: rdata_r <= {15'h0000, fields_r.lambda_x2};
        default:             rdata_r <= 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign avs_readdata            = rdata_r;
  assign avs_waitrequest         = wait_r;
  assign mb_fields               = fields_r;
  assign mb_fields_valid         = fvalid_r;
  assign overflow_emergency_mode = overflow_emergency_mode_r;
  assign coeff_limit             = limit_r;

endmodule

`default_nettype wire

// >>> verif/mbu_unpacker_checker.sv
// concurrent checks on the unpacker ports
// assumes a bind into mbu_unpacker, one clock domain
`timescale 1ns/1ns
`default_nettype none

module mbu_unpacker_checker (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic                    dw_valid,
  input wire logic                    dw_last,
  input wire logic [15:0]             packed_words,
  input wire logic                    avs_waitrequest,
  input wire mbu_pkg::mbu_fields_type mb_fields,
  input wire logic                    mb_fields_valid,
  input wire logic                    overflow_emergency_mode,
  input wire logic                    coeff_limit
);
  // ****
  // budget causes, strict greater than
  // ****
  logic over_c;  // cause of the emergency flag
  logic goal_c;  // cause of the limit flag
  assign over_c = packed_words > {8'h00, mb_fields.size_ceiling_words};
  assign goal_c = packed_words > {8'h00, mb_fields.size_goal_words};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****
  // properties
  // ****
  // first edge after reset still sees reset-time causes, so skip it
  chk_ceiling_cmp: assert property (
    !$past(reset) |-> overflow_emergency_mode == $past(over_c)) else $error("emergency flag off");
  chk_goal_cmp: assert property (
    !$past(reset) |-> coeff_limit == $past(goal_c)) else $error("limit flag off");
  chk_fields_hold: assert property (
    !$past(reset) && !mb_fields_valid |-> $stable(mb_fields)) else $error("fields moved");
  chk_commit_lag: assert property (
    dw_valid && dw_last |-> ##2 mb_fields_valid) else $error("commit late");
  chk_commit_cause: assert property (
    mb_fields_valid |-> $past(dw_valid, 2) && $past(dw_last, 2)) else $error("commit uncaused");
  chk_trellis_round: assert property (
    mb_fields.trellis_active |-> mb_fields.round_from_trellis && !mb_fields.round_from_slice)
    else $error("trellis rounding wrong");
  chk_lambda_idle: assert property (
    !mb_fields.trellis_active |-> mb_fields.lambda_x2 == 17'h00000) else $error("lambda without trellis");
  chk_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
endmodule

bind mbu_unpacker mbu_unpacker_checker chk_u (.clk_sys(clk_sys), .reset(reset), .dw_valid(dw_valid),
  .dw_last(dw_last), .packed_words(packed_words), .avs_waitrequest(avs_waitrequest), .mb_fields(mb_fields),
  .mb_fields_valid(mb_fields_valid), .overflow_emergency_mode(overflow_emergency_mode),
  .coeff_limit(coeff_limit));
`default_nettype wire

// >>> verif/mbu_cmd_feeder.sv
// command parser model feeding inline dwords
// assumes the bench loads dwords before pulsing start
`timescale 1ns/1ns
`default_nettype none

module mbu_cmd_feeder (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        start,       // one-cycle launch
  input  wire logic [31:0] dwords [24], // whole command
  output logic             dw_valid,
  output logic      [4:0]  dw_index,
  output logic      [31:0] dw_data,
  output logic             dw_last
);
  logic [5:0] cnt_r = 6'h18;  // 24 means idle
  // ****
  // walk all dwords, one a cycle
  // ****
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 6'h18;
    end else if (cnt_r != 6'h18) begin
      cnt_r <= cnt_r + 6'h01;
    end else if (start) begin
      cnt_r <= 6'h00;
    end
  end
  assign dw_valid = cnt_r != 6'h18;
  assign dw_index = cnt_r[4:0];
  // idle data is the inverse of the last dword, never a stale copy
  assign dw_data  = dw_valid ? dwords[cnt_r[4:0]] : ~dwords[23];
  assign dw_last  = cnt_r == 6'h17;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the macroblock inline unpacker
// assumes the feeder model and the bound checker compile first
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ****
  // bench signals
  // ****
  logic                    clk_sys = 1'b0;
  logic                    reset = 1'b1;
  logic                    start = 1'b0;  // feeder launch
  logic [31:0]             cmd [24];      // next command
  logic [31:0]             rd;            // last bus read
  logic [15:0]             packed_words = 16'h0000;
  logic [4:0]              avs_address = 5'h00;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = 32'h00000000;
  logic                    dw_valid, dw_last, wait_rq, f_valid, emerg, limit;
  logic [4:0]              dw_index;
  logic [31:0]             dw_data, rdata;
  mbu_pkg::mbu_fields_type f;
  int                      n_mismatch = 0;
  int                      checks_done = 0;
  int                      cyc = 0;

  initial forever #50 clk_sys = ~clk_sys;
  mbu_cmd_feeder feed_u (.clk_sys(clk_sys), .reset(reset), .start(start), .dwords(cmd),
    .dw_valid(dw_valid), .dw_index(dw_index), .dw_data(dw_data), .dw_last(dw_last));
  mbu_unpacker dut_u (.clk_sys(clk_sys), .reset(reset), .dw_valid(dw_valid), .dw_index(dw_index),
    .dw_data(dw_data), .dw_last(dw_last), .packed_words(packed_words), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wait_rq), .mb_fields(f), .mb_fields_valid(f_valid),
    .overflow_emergency_mode(emerg), .coeff_limit(limit));

  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (wait_rq !== 1'b0);
    rd = rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  // send a whole command and wait for its commit
  task automatic run_mb(input logic [31:0] d3, input logic [31:0] d6, input logic [31:0] d10);
    cmd[3] = d3;
    cmd[6] = d6;
    cmd[10] = d10;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    do @(posedge clk_sys); while (f_valid !== 1'b1);
  endtask
  task automatic mode_case(input logic [6:0] ctl, input logic [31:0] d3, input logic [63:0] exp);
    bus(1'b1, mbu_pkg::REG_CTRL, {25'h0, ctl});
    run_mb(d3, 32'h00000014, 32'h20100000);
    chk("luma_vec", f.luma_pred_modes, exp);
    chk("ref_intra", {f.ref_l0, f.ref_l1}, 64'h0);
    chk("aux_intra", f.layout_aux, cmd[9][7:0]);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the fewer than one thousand cycles needed
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ****
  // test sequence
  // ****
  initial begin
    for (int i = 0; i < 24; i++) begin
      cmd[i] = {8'hc0, 3'h0, i[4:0], 8'h30, 3'h0, i[4:0]};
    end
    cmd[20] = 32'h5a3c9e87;
    cmd[21] = 32'h1b2d4f60;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, mbu_pkg::REG_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h0);
    bus(1'b1, 5'h10, 32'hffffffff);  // hole, write dropped
    bus(1'b0, 5'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    // every rounding code, chroma bytes carry junk
    for (int c = 0; c < 16; c++) begin
      run_mb(32'h0, 32'h02a55a33, {16'h2010, 12'h000, c[3:0]});
      chk("slice_rnd", f.round_from_slice, c < 8);
      chk("rsv_rnd", f.round_reserved, c > 0 && c < 8);
      if (c > 7) chk("rnd_16ths", f.round_sixteenths, c - 7);
    end
    chk("skip_off", f.skip_conversion_off, 1'b1);
    chk("luma_qp", f.luma_quantizer, 8'h33);
    chk("budgets", {f.size_ceiling_words, f.size_goal_words}, 16'h2010);
    chk("ref_16x16", {f.ref_l0, f.ref_l1}, {24'h0, cmd[8][7:0], 24'h0, cmd[9][7:0]});
    chk("aux_inter", f.layout_aux, cmd[7][7:0]);
    for (int k = 0; k < 4; k++) begin
      chk("mv_fwd", f.mv_fwd[k], cmd[12 + k]);
      chk("mv_bwd", f.mv_bwd[k], cmd[16 + k]);
    end
    chk("costs", {f.best_cost, f.skip_cost, f.inter_cost, f.intra_cost}, {cmd[22], cmd[23]});
    $display("test inter_rounding done");
    // budget edges: at and one past each
    for (int k = 0; k < 4; k++) begin
      packed_words <= (k < 2) ? 16'h0010 + 16'(k) : 16'h001e + 16'(k);
      repeat (2) @(posedge clk_sys);
      chk("coeff_limit", limit, k > 0);
      chk("emergency", emerg, k == 3);
    end
    bus(1'b0, mbu_pkg::REG_STAT, 32'h0);
    chk("status", rd[15:0], 16'h1007);
    packed_words <= 16'h0000;
    bus(1'b1, mbu_pkg::REG_STAT, 32'h00000005);
    bus(1'b0, mbu_pkg::REG_STAT, 32'h0);
    chk("status_clr", rd[2:0], 3'h0);
    $display("test budgets done");
    // trellis on, setting 5, top legal lambda
    bus(1'b1, mbu_pkg::REG_CTRL, 32'h0000000b);
    run_mb(32'h0, 32'h00000014, 32'h2010efff);
    chk("tq_on", {f.trellis_active, f.round_from_trellis, f.round_sixteenths}, 6'h35);
    chk("lambda", f.lambda_x2, 17'h1dffe);
    bus(1'b0, mbu_pkg::REG_QP, 32'h0);
    chk("qp_reg", rd, 32'h20100114);
    run_mb(32'h0, 32'h00000014, 32'h2010f00c);
    chk("tq_off", {f.trellis_active, f.lambda_x2, f.round_sixteenths}, 22'h000005);
    chk("skip_on", f.skip_conversion_off, 1'b0);
    $display("test trellis done");
    mode_case(7'h00, 32'h00002000, {cmd[21], cmd[20]});
    mode_case(7'h20, 32'h00002000, {12'h0, cmd[20][15:12], 12'h0, cmd[20][11:8],
      12'h0, cmd[20][7:4], 12'h0, cmd[20][3:0]});
    mode_case(7'h00, 32'h00002100, {16{cmd[20][3:0]}});
    chk("intra16", f.intra16_mode, cmd[20][1:0]);
    mode_case(7'h10, 32'h00002100, {cmd[21], cmd[20]});
    bus(1'b1, mbu_pkg::REG_CTRL, 32'h00000010);
    run_mb(32'h0, 32'h00000014, 32'h20100000);
    chk("ref_repl", f.ref_l0, {4{cmd[8][7:0]}});
    run_mb(32'h00000002, 32'h00000014, 32'h20100000);
    chk("ref_8x16", f.ref_l1, {2{cmd[9][15:0]}});
    run_mb(32'h00000001, 32'h00000014, 32'h20100000);
    chk("ref_16x8", f.ref_l0, {16'h0, cmd[8][15:0]});
    run_mb(32'h00000003, 32'h00000014, 32'h20100000);
    chk("ref_8x8", {f.ref_l0, f.ref_l1}, {cmd[8], cmd[9]});
    chk("luma_inter", f.luma_pred_modes, 64'h0);
    $display("test layouts done");
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk("fields_rst", {f.luma_quantizer, f.size_ceiling_words, f.ref_l0}, 48'h0);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
